// ---- hw/dpm_top.sv ----
`timescale 1ns/100ps
`include "dpm_params.svh"
// Function
// - 36 Kbit storage, whole or two halves
// - full array shapes 32Kx1 to 512x72; here 512x72 only
// - half array shapes 16Kx1 to 512x36; here 256x72 per half
// - symmetric independent ports, own widths; here both fixed at 72 bits
// - write-time output: new, old or unchanged
// - split layout: write-only and read-only ports
// - split layout: fixed side, selectable side
// - two arrays cascade into 64Kx1; here two give 1024x72
// - byte write strobes on wide ports
// - inputs sampled on edge, one-edge accesses
// - output holds until next access, latched
// - pipeline register adds one cycle
// - stage clear loads clear value, priority select
// - gate priority: clear needs gate, latch untouched
// - latch clear needs port activate
// - parity only at 9, 18, 36, 72 widths
// - contents cleared at initialisation
// - split new-data request becomes unchanged
module dpm_top #(
  parameter int ROWS = `DPM_ROWS, // 72-bit rows
  parameter int ROW_W = `DPM_ROW_W // 64 data + 8 parity
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // port a
  input wire logic a_en_i,
  input wire logic [8:0] a_addr_i,
  input wire logic [8:0] a_we_i,
  input wire logic [71:0] a_din_i,
  input wire logic a_top_address_bit_i,
  input wire logic a_latch_clear_i,
  input wire logic a_output_stage_clear_i,
  input wire logic a_output_stage_clock_gate_i,
  output logic [71:0] a_dout_o,
  // port b
  input wire logic b_en_i,
  input wire logic [8:0] b_addr_i,
  input wire logic [8:0] b_we_i,
  input wire logic [71:0] b_din_i,
  input wire logic b_top_address_bit_i,
  input wire logic b_latch_clear_i,
  input wire logic b_output_stage_clear_i,
  input wire logic b_output_stage_clock_gate_i,
  output logic [71:0] b_dout_o
);
  // one row holds 8 bytes each with its parity bit: lane k is
  // data [8k+7:8k] and parity bit 64+k, so a x9 lane is one strobe
  localparam int AW = $clog2(ROWS);
  // ROWS should be a power of two: the sweep ends on the carry
  // into the top counter bit

  // all register state but the storage array, one struct
  typedef struct packed {
    // bus phase and read data
    dpm_pkg::dpm_bus_t bus;
    logic [31:0] rdat;
    // control fields and the clear value
    logic [6:0] ctrl;
    logic [71:0] clrv;
    // port output stages
    logic [71:0] a_lat;
    logic [71:0] a_reg;
    logic [71:0] b_lat;
    logic [71:0] b_reg;
    // self-clear sweep, top bit set when done
    logic [AW:0] init_cnt;
  } dpm_state_t;

  dpm_state_t s_q;
  dpm_state_t s_d;
  // storage array, written only by the clocked process
  logic [ROW_W-1:0] mem_q [ROWS];

  // decoded controls
  dpm_pkg::dpm_wmode_t req_mode;
  dpm_pkg::dpm_wmode_t eff_mode;
  // one wire per single-bit control field, plus the sweep busy flag
  logic split;
  logic pipe;
  logic prio_gate;
  logic casc;
  logic half;
  logic init_busy;
  // per-port row, select and write qualifiers
  logic [AW-1:0] a_row;
  logic [AW-1:0] b_row;
  logic a_sel;
  logic b_sel;
  logic a_wr;
  logic b_wr;
  // lane masks and merged row values
  logic [71:0] a_bitmask;
  logic [71:0] b_bitmask;
  logic [71:0] a_old;
  logic [71:0] b_old;
  logic [71:0] a_new;
  logic [71:0] b_new;
  // bus request as the slave sees it
  logic bus_req;

  // control fields hold until software rewrites them
  assign req_mode = dpm_pkg::dpm_wmode_t'(s_q.ctrl[1:0]);
  assign split = s_q.ctrl[`DPM_CTRL_SPLIT];
  assign pipe = s_q.ctrl[`DPM_CTRL_PIPE];
  assign prio_gate = s_q.ctrl[`DPM_CTRL_PRIO];
  assign casc = s_q.ctrl[`DPM_CTRL_CASC];
  assign half = s_q.ctrl[`DPM_CTRL_HALF];
  // split layout trades new-data readback for lower power
  assign eff_mode = (split && req_mode == dpm_pkg::DPM_NEW_DATA) ?
    dpm_pkg::DPM_UNCHANGED : req_mode;
  assign init_busy = ~s_q.init_cnt[AW];

  // half layout: port a's top row bit is forced low, port b's high, so each is 18 Kbit
  // and ports never see the other half's rows
  always_comb begin
    a_row = a_addr_i[AW-1:0];
    b_row = b_addr_i[AW-1:0];
    if (half) begin
      a_row[AW-1] = 1'b0;
      b_row[AW-1] = 1'b1;
    end
  end

  // cascade: top address bit picks this array; else it is ignored
  // with the bit held high an uncascaded array always answers
  assign a_sel = casc ? a_top_address_bit_i : 1'b1;
  assign b_sel = casc ? b_top_address_bit_i : 1'b1;

  // split layout: port a write-only, port b read-only
  assign a_wr = a_en_i && a_sel && |a_we_i && !init_busy;
  assign b_wr = b_en_i && b_sel && |b_we_i && !split && !init_busy;

  // per-lane strobes expand to data byte plus parity bit
  always_comb begin
    a_bitmask = '0;
    b_bitmask = '0;
    for (int k = 0; k < 8; k++) begin
      a_bitmask[8*k +: 8] = {8{a_we_i[k]}};
      b_bitmask[8*k +: 8] = {8{b_we_i[k]}};
      a_bitmask[64+k] = a_we_i[k];
      b_bitmask[64+k] = b_we_i[k];
    end
  end

  // both ports read the shared array on their own rows
  assign a_old = mem_q[a_row];
  assign b_old = mem_q[b_row];
  // read-modify-write of one row; unstrobed lanes keep their bits
  assign a_new = (a_old & ~a_bitmask) | (a_din_i & a_bitmask);
  assign b_new = (b_old & ~b_bitmask) | (b_din_i & b_bitmask);

  // array: one edge per write, init clears rows one per cycle
  always_ff @(posedge clk_i) begin
    if (init_busy) begin
      mem_q[s_q.init_cnt[AW-1:0]] <= '0;
    end else begin
      if (a_wr) begin
        mem_q[a_row] <= a_new;
      end
      // same-row same-edge writes: port b lands last, undefined use
      if (b_wr) begin
        mem_q[b_row] <= b_new;
      end
    end
  end

  assign bus_req = wb_cyc_i && wb_stb_i;

  // next-state logic for bus and both output stages
  always_comb begin
    s_d = s_q;
    // init sweep counter
    if (init_busy) begin
      s_d.init_cnt = s_q.init_cnt + 1'b1;
    end
    // wishbone: ack one cycle after the request, drop next cycle
    case (s_q.bus)
      dpm_pkg::DPM_BUS_IDLE: begin
        if (bus_req) begin
          s_d.bus = dpm_pkg::DPM_BUS_ACK;
          s_d.rdat = '0;
          // ctrl takes byte lane 0 only; other lanes are ignored
          if (wb_we_i) begin
            if (wb_adr_i == `DPM_REG_CTRL && wb_sel_i[0]) begin
              s_d.ctrl = wb_dat_i[6:0];
            end
            if (wb_adr_i == `DPM_REG_CLRV) begin
              for (int k = 0; k < 4; k++) begin
                if (wb_sel_i[k]) begin
                  s_d.clrv[8*k +: 8] = wb_dat_i[8*k +: 8];
                end
              end
            end
          end else begin
            // unmapped offsets read as zero
            case (wb_adr_i)
              `DPM_REG_CTRL: s_d.rdat = {25'h0, s_q.ctrl};
              `DPM_REG_STAT: s_d.rdat = {30'h0, eff_mode};
              `DPM_REG_CLRV: s_d.rdat = s_q.clrv[31:0];
              default: s_d.rdat = '0;
            endcase
          end
        end
      end
      dpm_pkg::DPM_BUS_ACK: begin
        s_d.bus = dpm_pkg::DPM_BUS_IDLE;
      end
      default: begin
        s_d.bus = dpm_pkg::DPM_BUS_IDLE;
      end
    endcase
    // port a latch; write-only in split layout so never reads then
    if (a_en_i && !init_busy) begin
      // clear outranks the access: a write still lands in the row
      // while the latch shows the clear value
      if (a_latch_clear_i) begin
        s_d.a_lat = s_q.clrv;
      end else if (a_sel && !split) begin
        if (!(|a_we_i)) begin
          s_d.a_lat = a_old;
        end else if (eff_mode == dpm_pkg::DPM_NEW_DATA) begin
          s_d.a_lat = a_new;
        end else if (eff_mode == dpm_pkg::DPM_OLD_DATA) begin
          s_d.a_lat = a_old;
        end
      end
    end
    // port b latch; read-only in split layout
    if (b_en_i && !init_busy) begin
      if (b_latch_clear_i) begin
        s_d.b_lat = s_q.clrv;
      end else if (b_sel) begin
        if (!(|b_we_i) || split) begin
          s_d.b_lat = b_old;
        end else if (eff_mode == dpm_pkg::DPM_NEW_DATA) begin
          s_d.b_lat = b_new;
        end else if (eff_mode == dpm_pkg::DPM_OLD_DATA) begin
          s_d.b_lat = b_old;
        end
      end
    end
    // pipeline stages: clear may override the gate or need it
    // the latch feeds the stage only on a gated edge
    if (a_output_stage_clear_i &&
        (!prio_gate || a_output_stage_clock_gate_i)) begin
      s_d.a_reg = s_q.clrv;
    end else if (a_output_stage_clock_gate_i) begin
      s_d.a_reg = s_q.a_lat;
    end
    if (b_output_stage_clear_i &&
        (!prio_gate || b_output_stage_clock_gate_i)) begin
      s_d.b_reg = s_q.clrv;
    end else if (b_output_stage_clock_gate_i) begin
      s_d.b_reg = s_q.b_lat;
    end
    // clear value upper bits: lower word into 63:32, lower byte into the parity bits
    s_d.clrv[71:32] = {s_d.clrv[7:0], s_d.clrv[31:0]};
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.bus <= dpm_pkg::DPM_BUS_IDLE;
      s_q.rdat <= '0;
      s_q.ctrl <= 7'(`DPM_CTRL_RST);
      s_q.clrv <= {8'h00, `DPM_CLRV_RST, `DPM_CLRV_RST};
      s_q.a_lat <= '0;
      s_q.a_reg <= '0;
      s_q.b_lat <= '0;
      s_q.b_reg <= '0;
      // sweep restarts; the array is cleared by it, not by reset
      s_q.init_cnt <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // output select: latch direct, or one cycle later via register
  assign a_dout_o = pipe ? s_q.a_reg : s_q.a_lat;
  assign b_dout_o = pipe ? s_q.b_reg : s_q.b_lat;
  // ack and read data come straight from the state register
  assign wb_ack_o = (s_q.bus == dpm_pkg::DPM_BUS_ACK);
  assign wb_dat_o = s_q.rdat;
endmodule : dpm_top

// ---- pkg/dpm_params.svh ----
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH
// register byte offsets (word aligned)
`define DPM_REG_CTRL 8'h00
`define DPM_REG_STAT 8'h04
`define DPM_REG_CLRV 8'h08
// ctrl field positions
`define DPM_CTRL_MODE_LSB 0
`define DPM_CTRL_SPLIT 2
`define DPM_CTRL_PIPE 3
`define DPM_CTRL_PRIO 4
`define DPM_CTRL_CASC 5
`define DPM_CTRL_HALF 6
// reset values
`define DPM_CTRL_RST 32'h0000_0000
`define DPM_CLRV_RST 32'h0000_0000
// storage geometry: one word per 72-bit row, 512 rows = 36 Kbit
`define DPM_ROWS 512
`define DPM_ROW_W 72
`define DPM_HALF_ROWS 256
`endif

// ---- pkg/dpm_pkg.sv ----
package dpm_pkg;
  // output behaviour while the write strobe is high
  typedef enum logic [1:0] {
    DPM_NEW_DATA = 2'h0,
    DPM_OLD_DATA = 2'h1,
    DPM_UNCHANGED = 2'h2
  } dpm_wmode_t;
  // bus slave phase, one-hot
  typedef enum logic [1:0] {
    DPM_BUS_IDLE = 2'h1,
    DPM_BUS_ACK = 2'h2
  } dpm_bus_t;
endpackage : dpm_pkg

// ---- tb/dpm_props.sv ----
`timescale 1ns/100ps
module dpm_props #(
  parameter int ROWS = 512
) (
  // clock, reset and bus
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // ports
  input wire logic a_en_i, a_latch_clear_i, a_output_stage_clear_i,
  input wire logic b_en_i, b_output_stage_clear_i,
  input wire logic [8:0] a_we_i,
  input wire logic [71:0] a_din_i, a_dout_o, b_dout_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] ctl_q; // shadow of split, pipe and mode bits
  int unsigned init_q; // counts out the self clear after reset
  logic rdy;
  logic [1:0] eff;
  assign rdy = init_q >= ROWS + 4;
  // split turns a new-data request into unchanged
  assign eff = (ctl_q[2] && ctl_q[1:0] == 2'h0) ? 2'h2 : ctl_q[1:0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= 4'h0;
      init_q <= 0;
    end else begin
      if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
        ctl_q <= wb_dat_i[3:0];
      if (!rdy) init_q <= init_q + 1;
    end
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_has_cause_a: assert property
    (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  ack_next_cycle_a: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o)
    else $error("ack late");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i &&
    !(wb_adr_i inside {8'h00, 8'h04, 8'h08}) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  stat_mode_a: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == 8'h04 |-> wb_dat_o[1:0] == eff) else $error("bad mode");
  idle_hold_a: assert property ((!a_en_i && !a_output_stage_clear_i &&
    !wb_cyc_i)[*2] |=> $stable(a_dout_o)) else $error("a out moved");
  b_idle_hold_a: assert property ((!b_en_i && !b_output_stage_clear_i &&
    !wb_cyc_i)[*2] |=> $stable(b_dout_o)) else $error("b out moved");
  new_data_a: assert property (rdy && a_en_i && a_we_i == 9'h1FF &&
    !a_latch_clear_i && !wb_cyc_i && ctl_q == 4'h0
    |=> a_dout_o == $past(a_din_i)) else $error("new data missing");
  keep_dout_a: assert property (rdy && a_en_i && |a_we_i &&
    !a_latch_clear_i && !wb_cyc_i && eff == 2'h2 && !ctl_q[3]
    |=> $stable(a_dout_o)) else $error("out changed on write");
  cover property (a_en_i && a_we_i == 9'h1FF);
  cover property (wb_ack_o && !wb_we_i);
  cover property (a_en_i && a_latch_clear_i);
endmodule : dpm_props
bind dpm_top dpm_props #(.ROWS(ROWS)) u_dpm_props (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .a_en_i(a_en_i), .a_latch_clear_i(a_latch_clear_i),
  .a_output_stage_clear_i(a_output_stage_clear_i), .b_en_i(b_en_i),
  .b_output_stage_clear_i(b_output_stage_clear_i), .a_we_i(a_we_i),
  .a_din_i(a_din_i), .a_dout_o(a_dout_o), .b_dout_o(b_dout_o));

// ---- tb/dpm_top_tb.sv ----
`timescale 1ns/100ps
module dpm_top_tb;
  localparam int ROWS = 16; // short self clear
  typedef struct {int due; logic sel; logic [71:0] v;} dpm_exp_t;
  dpm_exp_t q[$]; // port results due by cycle
  logic [31:0] wq[$]; // bus read results
  int cnt = 0, num_errors = 0, checks = 0;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic wb_ack_o, a_en_i = 0, a_lc = 0, b_rd = 0, b_slow = 0, b_en, b_top;
  logic b_lc, b_sc, b_g, a_sc = 0, a_g = 1, a_top = 1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r = 32'h4A;
  logic [8:0] a_addr_i = 9'h000, a_we_i = 9'h000, b_adr = 9'h000, b_addr;
  logic [8:0] b_we;
  logic [71:0] a_din_i = 72'h0, a_dout_o, b_dout_o, b_din, d, ea;
  logic [71:0] cv = {8'hA5, 32'h0000_00A5, 32'h0000_00A5}; // clear value
  logic [71:0] m[ROWS] = '{default: 72'h0};
  initial forever #2.5 clk_i = ~clk_i;
  dpm_top #(.ROWS(ROWS)) u_dpm_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .a_en_i(a_en_i),
    .a_addr_i(a_addr_i), .a_we_i(a_we_i), .a_din_i(a_din_i),
    .a_top_address_bit_i(a_top), .a_latch_clear_i(a_lc),
    .a_output_stage_clear_i(a_sc), .a_output_stage_clock_gate_i(a_g),
    .a_dout_o(a_dout_o), .b_en_i(b_en), .b_addr_i(b_addr), .b_we_i(b_we),
    .b_din_i(b_din), .b_top_address_bit_i(b_top), .b_latch_clear_i(b_lc),
    .b_output_stage_clear_i(b_sc), .b_output_stage_clock_gate_i(b_g),
    .b_dout_o(b_dout_o));
  dpm_user u_dpm_user (.clk_i(clk_i), .rst_i(rst_i), .rd_i(b_rd),
    .slow_i(b_slow), .adr_i(b_adr), .en_o(b_en), .top_o(b_top),
    .lclr_o(b_lc), .sclr_o(b_sc), .gate_o(b_g), .addr_o(b_addr),
    .we_o(b_we), .din_o(b_din));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // lanes 0..7 carry a byte and one parity bit each
  function automatic logic [71:0] mrg(input logic [71:0] o, n,
                                      input logic [8:0] we);
    mrg = o;
    for (int k = 0; k < 8; k++) if (we[k]) begin
      mrg[8*k +: 8] = n[8*k +: 8];
      mrg[64+k] = n[64+k];
    end
  endfunction : mrg
  task automatic cmp(input string n, input logic [71:0] e, s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // results are taken off the queues as they fall due
  always @(negedge clk_i) begin
    while (q.size() > 0 && q[0].due == cnt) begin
      cmp(q[0].sel ? "b_dout" : "a_dout", q[0].v,
          q[0].sel ? b_dout_o : a_dout_o);
      void'(q.pop_front());
    end
    cnt++;
  end
  always @(posedge clk_i) if (wb_ack_o && !wb_we_i && wq.size() > 0)
    cmp("wb_dat", {40'h0, wq.pop_front()}, {40'h0, wb_dat_o});
  // one classic cycle; entered just after an edge
  task automatic wb(input logic w, input logic [7:0] a, input int v);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    if (!w) wq.push_back(v);
    do @(posedge clk_i); while (!wb_ack_o && ++n < 50);
    if (n >= 50) num_errors++;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic pa(input logic en, lc, input logic [8:0] we,
                    input int ad, input logic [71:0] v, e, input int lat);
    @(posedge clk_i);
    a_en_i <= en;
    a_lc <= lc;
    a_we_i <= we;
    a_addr_i <= ad[8:0];
    a_din_i <= v;
    if (lat > 0) q.push_back('{cnt + lat, 1'b0, e});
    if (lat > 0) ea = e;
  endtask : pa
  task automatic brd(input int ad);
    @(posedge clk_i);
    b_rd <= 1;
    b_adr <= ad[8:0];
    q.push_back('{cnt + 2 + b_slow, 1'b1, m[ad]});
    @(posedge clk_i);
    b_rd <= 0;
  endtask : brd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    #10000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    repeat (ROWS + 8) @(posedge clk_i);
    wb(1, 8'h08, 32'h0000_00A5);
    wb(0, 8'h08, 32'h0000_00A5);
    wb(0, 8'hFC, 0);
    wb(1, 8'h00, 4);
    wb(0, 8'h00, 4);
    wb(0, 8'h04, 2);
    $display("test registers done");
    for (int md = 0; md < 3; md++) begin
      wb(1, 8'h00, md);
      b_slow <= md[0];
      r = lfsr(r);
      d = {r[7:0], r, ~r};
      pa(1, 0, 9'h1FF, md, d, md == 0 ? d : md == 1 ? m[md] : ea, 1);
      m[md] = d;
      pa(1, 0, 9'h101, md, ~d, 0, 0);
      m[md] = mrg(d, ~d, 9'h101);
      pa(1, 0, 9'h000, md, 0, m[md], 1);
      pa(0, 0, 9'h1FF, 5, d, ea, 1);
      brd(md);
      $display("test mode %0d done", md);
    end
    pa(1, 0, 9'h000, 1, 0, m[1], 1);
    pa(0, 1, 9'h000, 1, 0, m[1], 1);
    pa(1, 1, 9'h000, 1, 0, {8'hA5, 32'h0000_00A5, 32'h0000_00A5}, 1);
    pa(0, 0, 9'h000, 1, 0, 0, 0);
    wb(1, 8'h00, 8);
    pa(1, 0, 9'h000, 2, 0, m[2], 2);
    pa(1, 0, 9'h000, 0, 0, m[0], 2);
    pa(0, 0, 9'h000, 0, 0, 0, 0);
    $display("test latch and pipe done");
    wb(1, 8'h00, 24); // pipe, stage clear needs the gate
    @(posedge clk_i);
    a_sc <= 1;
    a_g <= 0;
    q.push_back('{cnt + 1, 1'b0, m[0]});
    @(posedge clk_i);
    a_g <= 1;
    q.push_back('{cnt + 1, 1'b0, cv});
    @(posedge clk_i);
    a_sc <= 0;
    q.push_back('{cnt + 1, 1'b0, m[0]});
    wb(1, 8'h00, 8); // stage clear overrides the gate
    @(posedge clk_i);
    a_sc <= 1;
    a_g <= 0;
    q.push_back('{cnt + 1, 1'b0, cv});
    @(posedge clk_i);
    a_sc <= 0;
    a_g <= 1;
    $display("test stage clear done");
    wb(1, 8'h00, 64); // half layout, new data
    r = lfsr(r);
    d = {r[7:0], r, ~r};
    pa(1, 0, 9'h1FF, 9, d, d, 1);
    m[1] = d;
    pa(1, 0, 9'h000, 1, 0, d, 1);
    pa(0, 0, 9'h000, 1, 0, d, 1);
    brd(9);
    wb(1, 8'h00, 32); // cascade, new data
    a_top <= 0;
    pa(1, 0, 9'h0FF, 1, ~d, d, 1);
    pa(0, 0, 9'h000, 1, 0, d, 1);
    a_top <= 1;
    pa(1, 0, 9'h000, 1, 0, d, 1);
    repeat (6) @(posedge clk_i);
    $display("test half and cascade done");
    end_of_test();
  end
endmodule : dpm_top_tb

// ---- tb/dpm_user.sv ----
`timescale 1ns/100ps
// read-only user of port b; slow_i adds one idle edge before the access
module dpm_user (
  input wire logic clk_i, rst_i, rd_i, slow_i,
  input wire logic [8:0] adr_i,
  output logic en_o, top_o, lclr_o, sclr_o, gate_o,
  output logic [8:0] addr_o, we_o,
  output logic [71:0] din_o
);
  logic pend_q;
  assign top_o = 1'b1;
  assign lclr_o = 1'b0;
  assign we_o = 9'h000;
  assign sclr_o = 1'b0;
  assign gate_o = 1'b1;
  // en stays low from reset until a request comes
  always_ff @(posedge clk_i) begin
    din_o <= rst_i ? 72'h0 : ~din_o; // unused data toggles every edge out of reset, held at zero in reset
    pend_q <= !rst_i && rd_i && slow_i;
    en_o <= !rst_i && ((rd_i && !slow_i) || pend_q);
    if (rd_i) addr_o <= adr_i;
  end
endmodule : dpm_user
